//--- bjc_defs.vh
// Purpose: shared constants of the branch and jump unit
// Assumes: included by bare name from the condition and unit design files
// Notes: flag positions follow the condition code register layout
`ifndef BJC_DEFS_VH
`define BJC_DEFS_VH
// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define BJC_OP_JMP_DIR 8'hbc
`define BJC_OP_JMP_EXT 8'hcc
`define BJC_OP_JMP_IX2 8'hdc
`define BJC_OP_JMP_IX1 8'hec
`define BJC_OP_JMP_IX 8'hfc
`define BJC_OP_ALWAYS 8'h20
`define BJC_OP_NEVER 8'h21
`define BJC_OP_U_HIGHER 8'h22
`define BJC_OP_U_LOWER_SAME 8'h23
`define BJC_OP_CARRY_CLEAR 8'h24
`define BJC_OP_CARRY_SET 8'h25
`define BJC_OP_NOT_EQUAL 8'h26
`define BJC_OP_EQUAL 8'h27
`define BJC_OP_HALF_CLEAR 8'h28
`define BJC_OP_HALF_SET 8'h29
`define BJC_OP_POSITIVE 8'h2a
`define BJC_OP_NEGATIVE 8'h2b
`define BJC_OP_MASK_CLEAR 8'h2c
`define BJC_OP_MASK_SET 8'h2d
`define BJC_OP_IRQ_LOW 8'h2e
`define BJC_OP_IRQ_HIGH 8'h2f
`define BJC_OP_S_GREATER_EQUAL 8'h90
`define BJC_OP_S_LESS 8'h91
`define BJC_OP_S_GREATER 8'h92
`define BJC_OP_S_LESS_EQUAL 8'h93
// ---------------------------------------------------------------
// Condition code register bit positions
// ---------------------------------------------------------------
`define BJC_CCR_V 7
`define BJC_CCR_H 4
`define BJC_CCR_I 3
`define BJC_CCR_N 2
`define BJC_CCR_Z 1
`define BJC_CCR_C 0
// ---------------------------------------------------------------
// Bus cycles per instruction
// ---------------------------------------------------------------
`define BJC_CYC_DIR 3'd3
`define BJC_CYC_EXT 3'd4
`define BJC_CYC_IX2 3'd4
`define BJC_CYC_IX1 3'd3
`define BJC_CYC_IX 3'd3
`define BJC_CYC_REL 3'd3
// ---------------------------------------------------------------
// Register map, fields and reset values
// ---------------------------------------------------------------
`define BJC_ADDR_CTRL 8'h00
`define BJC_ADDR_STATUS 8'h04
`define BJC_ADDR_TARGET 8'h08
`define BJC_ADDR_TAKEN 8'h0c
`define BJC_ADDR_FALL 8'h10
`define BJC_CTRL_EN_BIT 0
`define BJC_ST_BUSY_BIT 0
`define BJC_ST_TAKEN_BIT 1
`define BJC_ST_ILL_BIT 2
`define BJC_CTRL_RST 1'b1
`define BJC_RESP_OKAY 2'b00
`define BJC_RESP_DECERR 2'b11
`endif

//--- bjc_sync.v
// Purpose: two-stage synchroniser for an outside level
// Assumes: single destination clock
// Notes: first stage is read by the second stage only
module bjc_sync (
   input wire clk,
   input wire resetn,
   input wire din,
   output wire dout
);
   reg meta_reg;
   reg sync_reg;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end

   assign dout = sync_reg;
endmodule

//--- bjc_cond.v
// Purpose: branch condition evaluation
// Assumes: opcode is a relative branch; any other opcode gives take low
// Notes: purely combinational; flags are only read here
`include "bjc_defs.vh"
module bjc_cond (
   input wire [7:0] opcode,
   input wire [7:0] condition_code_register,
   input wire irq_level,
   output reg take
);
   wire v = condition_code_register[`BJC_CCR_V];
   wire h = condition_code_register[`BJC_CCR_H];
   wire i = condition_code_register[`BJC_CCR_I];
   wire n = condition_code_register[`BJC_CCR_N];
   wire z = condition_code_register[`BJC_CCR_Z];
   wire c = condition_code_register[`BJC_CCR_C];
   wire nxv = n ^ v;

   always @* begin
      case (opcode)
         `BJC_OP_ALWAYS: take = 1'b1;
         `BJC_OP_NEVER: take = 1'b0;
         `BJC_OP_EQUAL: take = z;
         `BJC_OP_NOT_EQUAL: take = ~z;
         `BJC_OP_CARRY_CLEAR: take = ~c;
         `BJC_OP_CARRY_SET: take = c;
         `BJC_OP_POSITIVE: take = ~n;
         `BJC_OP_NEGATIVE: take = n;
         `BJC_OP_IRQ_LOW: take = ~irq_level;
         `BJC_OP_IRQ_HIGH: take = irq_level;
         `BJC_OP_MASK_CLEAR: take = ~i;
         `BJC_OP_MASK_SET: take = i;
         `BJC_OP_HALF_CLEAR: take = ~h;
         `BJC_OP_HALF_SET: take = h;
         `BJC_OP_S_LESS: take = nxv;
         `BJC_OP_S_GREATER_EQUAL: take = ~nxv;
         `BJC_OP_S_LESS_EQUAL: take = z | nxv;
         `BJC_OP_S_GREATER: take = ~(z | nxv);
         `BJC_OP_U_LOWER_SAME: take = c | z;
         `BJC_OP_U_HIGHER: take = ~(c | z);
         default: take = 1'b0;
      endcase
   end
endmodule

//--- bjc_unit.v
// Purpose: change-of-flow unit: jumps and relative branches
// Assumes: core hands over one opcode at a time; fetch data one cycle after request
// Notes: registers reached over AXI4-Lite
//
// Function
// - An absolute jump loads the program counter with a target anywhere in 64 Kbytes (direct mode: first 256 bytes only), in 3 or 4 cycles by mode.
// - A relative target is a signed 8-bit offset added to the address after the offset byte.
// - Branch-always redirects regardless of flags; every relative branch takes 3 bus cycles.
// - Branch-never never redirects and acts as a two-byte, three-cycle no-operation.
// - Opcode 27 branches on zero set, 26 on zero clear.
// - Opcode 24 branches on carry clear, 25 on carry set.
// - Opcode 2A branches on negative clear, 2B on negative set.
// - Opcode 2E branches on a low interrupt pin, 2F on a high one, ignoring flags.
// - Opcode 2C branches on interrupt mask clear, 2D on mask set.
// - Opcode 28 branches on half-carry clear, 29 on half-carry set.
// - Opcode 91 branches when negative xor overflow is one, 90 when it is zero.
// - Opcode 93 branches when zero or (negative xor overflow) is one, 92 when it is zero.
// - Opcode 23 branches when carry or zero is one, 22 when it is zero.
// - A false condition continues after the branch; only a true one redirects.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "bjc_defs.vh"
module bjc_unit (
   input wire clk,
   input wire resetn,
   input wire instr_valid,
   output wire instr_ready,
   input wire [7:0] instr_opcode,
   input wire [15:0] instr_pc,
   input wire [15:0] instr_hx,
   input wire [7:0] ccr_in,
   input wire irq_pin,
   output reg fetch_req,
   output reg [15:0] fetch_addr,
   input wire [7:0] fetch_data,
   output reg done,
   output reg [15:0] new_pc,
   output reg branch_taken,
   output reg [7:0] ccr_out,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // {known, relative, operand bytes, total cycles}
   function [6:0] decode;
      input [7:0] op;
      begin
         case (op)
            `BJC_OP_JMP_DIR: decode = {2'b10, 2'd1, `BJC_CYC_DIR};
            `BJC_OP_JMP_EXT: decode = {2'b10, 2'd2, `BJC_CYC_EXT};
            `BJC_OP_JMP_IX2: decode = {2'b10, 2'd2, `BJC_CYC_IX2};
            `BJC_OP_JMP_IX1: decode = {2'b10, 2'd1, `BJC_CYC_IX1};
            `BJC_OP_JMP_IX: decode = {2'b10, 2'd0, `BJC_CYC_IX};
            default: begin
               if (op[7:4] == 4'h2 || op[7:2] == 6'b100100) begin
                  decode = {2'b11, 2'd1, `BJC_CYC_REL};
               end else begin
                  decode = 7'h00;
               end
            end
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   reg state_reg;
   reg [2:0] cyc_reg;
   reg [2:0] total_reg;
   reg [1:0] nbytes_reg;
   reg rel_reg;
   reg [7:0] op_reg;
   reg [15:0] pc_reg;
   reg [15:0] hx_reg;
   reg [15:0] opnd_reg;
   reg rd_pend_reg;
   reg enable_reg;
   reg ill_reg;
   reg [15:0] taken_cnt_reg;
   reg [15:0] fall_cnt_reg;

   wire irq_level;
   wire cond_take;
   wire [6:0] dec = decode(instr_opcode);
   wire accept = instr_valid & instr_ready;
   wire finish = (state_reg == ST_RUN) && (cyc_reg == total_reg - 3'd1);

   assign instr_ready = enable_reg & (state_reg == ST_IDLE);

   bjc_sync u_irq_sync (
      .clk(clk),
      .resetn(resetn),
      .din(irq_pin),
      .dout(irq_level)
   );

   // Flags held from accept, so no outside write can change them mid-branch
   bjc_cond u_cond (
      .opcode(op_reg),
      .condition_code_register(ccr_out),
      .irq_level(irq_level),
      .take(cond_take)
   );

   // ---------------------------------------------------------------
   // Target arithmetic
   // ---------------------------------------------------------------
   wire [15:0] opnd_now = rd_pend_reg ? {opnd_reg[7:0], fetch_data} : opnd_reg;
   wire [15:0] fall_pc = pc_reg + {14'h0000, nbytes_reg};
   wire [15:0] disp_ext = {{8{opnd_now[7]}}, opnd_now[7:0]};
   wire [15:0] rel_pc = fall_pc + disp_ext;
   reg [15:0] jump_pc;

   always @* begin
      case (op_reg)
         `BJC_OP_JMP_DIR: jump_pc = {8'h00, opnd_now[7:0]};
         `BJC_OP_JMP_EXT: jump_pc = opnd_now;
         `BJC_OP_JMP_IX2: jump_pc = hx_reg + opnd_now;
         `BJC_OP_JMP_IX1: jump_pc = hx_reg + {8'h00, opnd_now[7:0]};
         default: jump_pc = hx_reg;
      endcase
   end

   wire redirect = rel_reg ? cond_take : 1'b1;
   wire [15:0] target_pc = rel_reg ? rel_pc : jump_pc;
   wire [15:0] result_pc = redirect ? target_pc : fall_pc;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         cyc_reg <= 3'd0;
         total_reg <= 3'd0;
         nbytes_reg <= 2'd0;
         rel_reg <= 1'b0;
         op_reg <= 8'h00;
         pc_reg <= 16'h0000;
         hx_reg <= 16'h0000;
         ccr_out <= 8'h00;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (accept) begin
                  op_reg <= instr_opcode;
                  ccr_out <= ccr_in;
               end
               if (accept && dec[6]) begin
                  state_reg <= ST_RUN;
                  cyc_reg <= 3'd1;
                  total_reg <= dec[2:0];
                  nbytes_reg <= dec[4:3];
                  rel_reg <= dec[5];
                  pc_reg <= instr_pc;
                  hx_reg <= instr_hx;
               end
            end
            ST_RUN: begin
               if (finish) begin
                  state_reg <= ST_IDLE;
                  cyc_reg <= 3'd0;
               end else begin
                  cyc_reg <= cyc_reg + 3'd1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Operand fetch
   // ---------------------------------------------------------------
   // Data are expected in the cycle after each request
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fetch_req <= 1'b0;
         fetch_addr <= 16'h0000;
         rd_pend_reg <= 1'b0;
         opnd_reg <= 16'h0000;
      end else begin
         rd_pend_reg <= fetch_req;
         if (rd_pend_reg) begin
            opnd_reg <= {opnd_reg[7:0], fetch_data};
         end
         if (accept && dec[6] && dec[4:3] != 2'd0) begin
            fetch_req <= 1'b1;
            fetch_addr <= instr_pc;
         end else if (state_reg == ST_RUN && {1'b0, nbytes_reg} > cyc_reg) begin
            fetch_req <= 1'b1;
            fetch_addr <= pc_reg + {13'h0000, cyc_reg};
         end else begin
            fetch_req <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Completion
   // ---------------------------------------------------------------
   // Unknown opcodes finish at once at the given address and flag it
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
         new_pc <= 16'h0000;
         branch_taken <= 1'b0;
      end else begin
         done <= 1'b0;
         if (finish) begin
            done <= 1'b1;
            new_pc <= result_pc;
            branch_taken <= redirect;
         end else if (accept && !dec[6]) begin
            done <= 1'b1;
            new_pc <= instr_pc;
            branch_taken <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Statistics
   // ---------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         taken_cnt_reg <= 16'h0000;
         fall_cnt_reg <= 16'h0000;
      end else if (finish) begin
         if (redirect) begin
            taken_cnt_reg <= taken_cnt_reg + 16'h0001;
         end else begin
            fall_cnt_reg <= fall_cnt_reg + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   reg aw_full_reg;
   reg w_full_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;

   wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   wire wr_mapped = (aw_addr_reg == `BJC_ADDR_CTRL) || (aw_addr_reg == `BJC_ADDR_STATUS) ||
                    (aw_addr_reg == `BJC_ADDR_TARGET) || (aw_addr_reg == `BJC_ADDR_TAKEN) ||
                    (aw_addr_reg == `BJC_ADDR_FALL);
   wire clr_ill = wr_fire && aw_addr_reg == `BJC_ADDR_STATUS && w_strb_reg[0] &&
                  w_data_reg[`BJC_ST_ILL_BIT];

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BJC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `BJC_RESP_OKAY : `BJC_RESP_DECERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control and sticky status
   // ---------------------------------------------------------------
   // A new unknown opcode in the clearing cycle keeps the flag set
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable_reg <= `BJC_CTRL_RST;
         ill_reg <= 1'b0;
      end else begin
         if (wr_fire && aw_addr_reg == `BJC_ADDR_CTRL && w_strb_reg[0]) begin
            enable_reg <= w_data_reg[`BJC_CTRL_EN_BIT];
         end
         if (accept && !dec[6]) begin
            ill_reg <= 1'b1;
         end else if (clr_ill) begin
            ill_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   reg [31:0] rd_mux;
   reg rd_hit;

   always @* begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         `BJC_ADDR_CTRL: rd_mux[`BJC_CTRL_EN_BIT] = enable_reg;
         `BJC_ADDR_STATUS: begin
            rd_mux[`BJC_ST_BUSY_BIT] = state_reg;
            rd_mux[`BJC_ST_TAKEN_BIT] = branch_taken;
            rd_mux[`BJC_ST_ILL_BIT] = ill_reg;
            rd_mux[15:8] = op_reg;
         end
         `BJC_ADDR_TARGET: rd_mux[15:0] = new_pc;
         `BJC_ADDR_TAKEN: rd_mux[15:0] = taken_cnt_reg;
         `BJC_ADDR_FALL: rd_mux[15:0] = fall_cnt_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `BJC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `BJC_RESP_OKAY : `BJC_RESP_DECERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

//--- bjc_unit_checker.sv
// Purpose: port assertions for the change-of-flow unit
// Assumes: fetch data is returned the cycle after its request
// Notes: relative targets use the offset byte the unit saw
module bjc_unit_checker (
   input wire clk,
   input wire resetn,
   input wire instr_valid,
   input wire instr_ready,
   input wire [7:0] instr_opcode,
   input wire [15:0] instr_pc,
   input wire [15:0] instr_hx,
   input wire [7:0] ccr_in,
   input wire fetch_req,
   input wire [15:0] fetch_addr,
   input wire [7:0] fetch_data,
   input wire done,
   input wire [15:0] new_pc,
   input wire branch_taken,
   input wire [7:0] ccr_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] fd_q;
   wire acc = instr_valid && instr_ready;
   wire rel = acc && (instr_opcode[7:4] == 4'h2 || instr_opcode[7:2] == 6'h24);
   wire [15:0] off = {{8{fd_q[7]}}, fd_q};
   // ---------------------------------------------
   // Offset byte as sampled one edge before done
   // ---------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fd_q <= 8'h00;
      end else begin
         fd_q <= fetch_data;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_REL_CYC: assert property (rel |=> !done [*2] ##1 done)
      else $error("relative branch length wrong");
   AST_JMP_LONG: assert property (acc && (instr_opcode == 8'hcc || instr_opcode == 8'hdc)
      |=> !done [*3] ##1 done) else $error("long jump length wrong");
   AST_JMP_IDX: assert property (acc && instr_opcode == 8'hfc
      |-> ##3 done && new_pc == $past(instr_hx, 3)) else $error("indexed jump wrong");
   AST_NEVER: assert property (rel && instr_opcode == 8'h21
      |-> ##3 !branch_taken && new_pc == $past(instr_pc, 3) + 16'h0001) else $error("branch never moved");
   AST_ALWAYS: assert property (rel && instr_opcode == 8'h20 |-> ##3 branch_taken)
      else $error("branch always not taken");
   AST_TARGET: assert property (rel |-> ##3 (!branch_taken || new_pc == $past(instr_pc, 3) + 16'h0001 + off))
      else $error("branch target wrong");
   AST_FALL: assert property (rel |-> ##3 (branch_taken || new_pc == $past(instr_pc, 3) + 16'h0001))
      else $error("fall-through address wrong");
   AST_ZERO: assert property (rel && instr_opcode[7:1] == 7'h13
      |-> ##3 branch_taken == ($past(instr_opcode[0], 3) == $past(ccr_in[1], 3))) else $error("zero branch wrong");
   AST_FETCH: assert property (rel |=> fetch_req && fetch_addr == $past(instr_pc))
      else $error("offset fetch wrong");
   AST_CCR: assert property (acc |=> ccr_out == $past(ccr_in))
      else $error("flags changed");
   COV_TAKEN: cover property (rel ##3 branch_taken);
   COV_FALL: cover property (rel ##3 !branch_taken);
   COV_EXT: cover property (acc && instr_opcode == 8'hcc);
endmodule

bind bjc_unit bjc_unit_checker i_bjc_unit_checker (.clk, .resetn, .instr_valid, .instr_ready, .instr_opcode,
   .instr_pc, .instr_hx, .ccr_in, .fetch_req, .fetch_addr, .fetch_data, .done, .new_pc, .branch_taken, .ccr_out);

//--- tb_top.sv
// Purpose: self-checking bench for the change-of-flow unit
// Assumes: 10 MHz clock, registers over AXI4-Lite
// Notes: fetch bytes come from a small memory indexed by the low address byte
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   logic [7:0] instr_opcode = 8'h00;
   logic [15:0] instr_pc = 16'h0000;
   logic [15:0] instr_hx = 16'h0000;
   logic [7:0] ccr_in = 8'h00;
   logic irq_pin = 1'b0;
   logic [7:0] fetch_data = 8'h00;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire instr_ready, fetch_req, done, branch_taken, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid;
   wire [15:0] fetch_addr, new_pc;
   wire [7:0] ccr_out;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [7:0] mem [0:255];
   int n_mismatch = 0;
   int checks = 0;

   bjc_unit i_bjc_unit (.clk, .resetn, .instr_valid, .instr_ready, .instr_opcode, .instr_pc, .instr_hx, .ccr_in,
      .irq_pin, .fetch_req, .fetch_addr, .fetch_data, .done, .new_pc, .branch_taken, .ccr_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   always #50 clk = ~clk;

   // Idle cycles return a changing byte so a late read is caught
   always @(posedge clk) begin
      fetch_data <= fetch_req ? mem[fetch_addr[7:0]] : ~fetch_data;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Runs one instruction; a one-cycle expectation skips the new_pc and taken checks
   task automatic exec(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] c, input logic [15:0] epc,
                       input logic etk, input int ecyc);
      int n;
      n = 0;
      instr_opcode <= op;
      instr_pc <= pc;
      ccr_in <= c;
      instr_valid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (!instr_ready && n < 50);
      instr_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!done && n < 50);
      chk("cycles", n, ecyc);
      chk("flags", {24'h0, ccr_out}, {24'h0, c});
      if (ecyc > 1) begin
         chk("new_pc", {16'h0, new_pc}, {16'h0, epc});
         chk("taken", {31'h0, branch_taken}, {31'h0, etk});
      end
   endtask

   function automatic logic take_of(input logic [7:0] op, input logic [7:0] c, input logic q);
      logic nv;
      nv = c[2] ^ c[7];
      case (op)
         8'h20: take_of = 1'b1;
         8'h21: take_of = 1'b0;
         8'h22: take_of = !(c[0] | c[1]);
         8'h23: take_of = c[0] | c[1];
         8'h24, 8'h25: take_of = c[0] == op[0];
         8'h26, 8'h27: take_of = c[1] == op[0];
         8'h28, 8'h29: take_of = c[4] == op[0];
         8'h2a, 8'h2b: take_of = c[2] == op[0];
         8'h2c, 8'h2d: take_of = c[3] == op[0];
         8'h2e, 8'h2f: take_of = q == op[0];
         8'h90, 8'h91: take_of = nv == op[0];
         default: take_of = (c[1] | nv) == op[0];
      endcase
   endfunction

   logic [7:0] rel_ops [20] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a,
      8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h90, 8'h91, 8'h92, 8'h93};
   logic [7:0] ccr_pat [7] = '{8'h00, 8'h9f, 8'h84, 8'h04, 8'h80, 8'h02, 8'h01};

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run;
   end

   initial begin
      logic [7:0] rr;
      logic [15:0] pc;
      logic tk;
      logic [31:0] d, t0, f0;
      logic [1:0] r;
      int n_tk, n_fl;
      n_tk = 0;
      n_fl = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // ---------------------------------------------
      // Register map basics
      // ---------------------------------------------
      axi_rd(8'h00, d, r);
      chk("ctrl reset", d, 32'h1);
      axi_rd(8'h20, d, r);
      chk("unmapped read", {30'h0, r}, 32'h3);
      axi_wr(8'h24, 32'h1, r);
      chk("unmapped write", {30'h0, r}, 32'h3);
      axi_wr(8'h00, 32'h0, r);
      instr_valid <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ready when off", {31'h0, instr_ready}, 32'h0);
      instr_valid <= 1'b0;
      axi_wr(8'h00, 32'h1, r);
      // ---------------------------------------------
      // Every relative branch, flags and pin both ways
      // ---------------------------------------------
      axi_rd(8'h0c, t0, r);
      axi_rd(8'h10, f0, r);
      for (int q = 0; q < 2; q++) begin
         irq_pin <= q[0];
         // Pin passes a synchroniser, so let it settle
         repeat (4) @(posedge clk);
         foreach (ccr_pat[p]) foreach (rel_ops[k]) begin
            rr = (k % 2) ? 8'h80 : 8'h7f;
            pc = (p % 2) ? 16'hfff0 : 16'h0040;
            mem[pc[7:0]] = rr;
            tk = take_of(rel_ops[k], ccr_pat[p], q[0]);
            exec(rel_ops[k], pc, ccr_pat[p], pc + 16'h0001 + (tk ? {{8{rr[7]}}, rr} : 16'h0000), tk, 3);
            if (tk) n_tk++;
            else n_fl++;
         end
      end
      axi_rd(8'h0c, d, r);
      chk("taken count", d, {16'h0, t0[15:0] + n_tk[15:0]});
      axi_rd(8'h10, d, r);
      chk("fall count", d, {16'h0, f0[15:0] + n_fl[15:0]});
      // ---------------------------------------------
      // Jumps in every mode, index sums wrapping
      // ---------------------------------------------
      instr_hx <= 16'hff80;
      mem[8'h10] = 8'hbe;
      mem[8'h11] = 8'hef;
      exec(8'hbc, 16'h0010, 8'h9f, 16'h00be, 1'b1, 3);
      exec(8'hcc, 16'h0010, 8'h00, 16'hbeef, 1'b1, 4);
      exec(8'hdc, 16'h0010, 8'h55, 16'hbe6f, 1'b1, 4);
      exec(8'hec, 16'h0010, 8'haa, 16'h003e, 1'b1, 3);
      exec(8'hfc, 16'h0010, 8'h13, 16'hff80, 1'b1, 3);
      axi_rd(8'h08, d, r);
      chk("target reg", d, 32'h0000_ff80);
      // ---------------------------------------------
      // Unknown opcode: sticky status, write one clears
      // ---------------------------------------------
      exec(8'h9d, 16'h0010, 8'h00, 16'h0000, 1'b0, 1);
      axi_rd(8'h04, d, r);
      chk("status", d & 32'hff04, 32'h9d04);
      axi_wr(8'h04, 32'h4, r);
      axi_rd(8'h04, d, r);
      chk("status cleared", d & 32'h4, 32'h0);
      complete_run;
   end
endmodule
